// [tb/rxcpm_host.sv]
/*
 rxcpm_host: host model, AHB-Lite master doing word accesses by index.
 assumes: one slave whose hreadyout is hready.
*/
`timescale 1ns/1ps
module rxcpm_host (
	input wire logic mclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	logic ok;
	logic [31:0] nd;
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// hready moves only on a rising edge, so the falling edge samples it race-free
	task automatic wt(output logic [31:0] d);
		do begin
			@(negedge mclk);
			ok = hready;
			d = hrdata;
			@(posedge mclk);
		end while (ok !== 1'b1);
	endtask
	task automatic req(input logic [4:0] i, input logic w);
		hsel <= 1'b1;
		haddr <= {25'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		wt(nd);
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask
	// run start is a plain write with the run bit clear, overflow clear a plain write with the bit set
	task automatic wr(input logic [4:0] i, input logic [31:0] d);
		req(i, 1'b1);
		hwdata <= d;
		wt(nd);
	endtask
	task automatic rd(input logic [4:0] i, output logic [31:0] d);
		req(i, 1'b0);
		wt(d);
	endtask
endmodule // rxcpm_host

// [tb/rxcpm_tb_top.sv]
/*
 rxcpm_tb_top: register, correction and matcher tests of rxcpm_top.
 assumes: default strength thresholds, short correction run.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
module rxcpm_tb_top;
	logic mclk, hsel, hwrite, hready, hreadyout, hresp, det, fil, bitsync_off, rssi_on;
	logic rssi_high_range, iq_amp_on, mode_linear, pattern_detect, fifo_fill_start;
	logic filter_calib, filter_init, nrst = 1'b0, rx_bit = 1'b0, rx_bit_valid = 1'b0;
	logic fill_select = 1'b0, freq_err_meas_valid = 1'b0;
	logic [31:0] haddr, hwdata, hrdata, rv, pat;
	logic [1:0] htrans;
	logic [2:0] hsize, filter_bw_code;
	logic [15:0] freq_err_meas = 16'h0000, lo_correction, lo;
	logic [7:0] power_level = 8'h00;
	logic [7:0] lv [7] = '{8'h00, 8'h40, 8'h41, 8'h80, 8'h81, 8'hc0, 8'hff};
	logic [1:0] bx [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
	int mismatches = 0, n_compared = 0, cycles = 0;
	assign hready = hreadyout;
	rxcpm_top #(.afc_cycles(16'h0010)) i_dut (.mclk, .nrst, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .power_level,
		.freq_err_meas, .freq_err_meas_valid, .rx_bit, .rx_bit_valid, .fill_select,
		.filter_bw_code, .filter_calib, .filter_init, .bitsync_off, .rssi_on,
		.rssi_high_range, .iq_amp_on, .mode_linear, .lo_correction, .pattern_detect,
		.fifo_fill_start);
	rxcpm_host i_host (.mclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata);
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [4:0] i, input logic [31:0] m, input logic [31:0] e);
		i_host.rd(i, rv);
		`CHK(rv & m, e)
		`CHK(hresp, 1'b0)
	endtask
	task automatic meas(input logic [15:0] v, input int n);
		freq_err_meas <= v;
		freq_err_meas_valid <= 1'b1;
		repeat (n) @(posedge mclk);
		freq_err_meas_valid <= 1'b0;
		repeat (20) @(posedge mclk);
	endtask
	// detection for the bits before this one shows in the cycle after its strobe
	task automatic sbit(input logic b);
		rx_bit <= b;
		rx_bit_valid <= 1'b1;
		@(posedge mclk);
		rx_bit_valid <= 1'b0;
		@(negedge mclk);
		det = pattern_detect;
		fil = fifo_fill_start;
		@(posedge mclk);
	endtask
	task automatic send(input int n, input int f);
		for (int i = 0; i < n; i++) sbit(pat[31 - i] ^ (i < f));
		sbit(1'b0);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		for (int i = 8; i <= 16; i++) chk(5'(i), 32'hffff_ffff, 32'h0);
		i_host.wr(5'h11, 32'h0000_00ff);
		chk(5'h11, 32'hffff_ffff, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			i_host.wr(5'h8, {25'h0, k[1:0], 1'b0, k[1:0], k[1:0]});
			chk(5'h8, 32'hffff_ffff, {25'h0, k[1:0], 1'b0, k[1:0], k[1:0]});
			`CHK(filter_bw_code, {1'b0, k[1:0]})
		end
		i_host.wr(5'h8, 32'h0000_0070);
		repeat (2) @(posedge mclk);
		`CHK(filter_bw_code, 3'h4)
		for (int i = 0; i < 7; i++) begin
			power_level <= lv[i];
			repeat (2) @(posedge mclk);
			chk(5'h9, 32'h0000_0030, {26'h0, bx[i], 4'h0});
		end
		$display("test filter and strength done");
		i_host.wr(5'h9, 32'h0000_0008);
		chk(5'h9, 32'h0000_000c, 32'h0000_000c);
		meas(16'hfff0, 1);
		chk(5'hb, 32'hffff_ffff, 32'h0000_00ff);
		chk(5'hc, 32'hffff_ffff, 32'h0000_00f0);
		chk(5'h9, 32'h0000_0006, 32'h0);
		`CHK(lo_correction, 16'hfff0)
		i_host.wr(5'h9, 32'h0000_0008);
		meas(16'h7fff, 4);
		chk(5'h9, 32'h0000_0006, 32'h0000_0002);
		chk(5'ha, 32'h0000_0080, 32'h0000_0080);
		i_host.wr(5'ha, 32'h0000_0080);
		chk(5'ha, 32'h0000_0080, 32'h0);
		lo = lo_correction;
		i_host.wr(5'h9, 32'h0000_0009);
		meas(16'h0020, 1);
		`CHK(lo_correction, lo)
		$display("test correction done");
		pat = 32'h93aa_93aa;
		for (int j = 0; j < 4; j++) i_host.wr(5'hd + 5'(j), {24'h0, pat[31 - 8 * j -: 8]});
		chk(5'hd, 32'hffff_ffff, 32'h0000_0093);
		send(8, 0);
		`CHK(det, 1'b0)
		// each case ends one error past tolerance, so a wrong count shows at once
		for (int s = 0; s < 4; s++) begin
			for (int e = 0; e < 2; e++) begin
				fill_select <= s[0];
				i_host.wr(5'ha, 32'h0);
				i_host.wr(5'ha, {26'h0, s[1], 1'b1, s[1:0], s[1:0]});
				send(8 * (s + 1), s + e);
				`CHK(det, 1'(e == 0))
				`CHK(fil, 1'(e == 0 && !s[0]))
				`CHK(mode_linear, s[1])
			end
		end
		// plain stored bits must reach their output pins
		i_host.wr(5'h8, 32'h0000_0080);
		i_host.wr(5'h9, 32'h0000_00c4);
		i_host.wr(5'ha, 32'h0000_0040);
		repeat (2) @(posedge mclk);
		`CHK({bitsync_off, rssi_on, rssi_high_range, iq_amp_on, mode_linear}, 5'h1e)
		$display("test pattern done");
		test_done();
	end
endmodule // rxcpm_tb_top

// [tb/rxcpm_top_assertions.sv]
/*
 rxcpm_top_chk: port checks of the receiver settings block.
 assumes: bound to rxcpm_top, one word write at a time.
*/
`timescale 1ns/1ps
module rxcpm_top_chk (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic rx_bit_valid,
	input wire logic fill_select,
	input wire logic [2:0] filter_bw_code,
	input wire logic filter_calib,
	input wire logic filter_init,
	input wire logic mode_linear,
	input wire logic [15:0] lo_correction,
	input wire logic pattern_detect,
	input wire logic fifo_fill_start
);
	logic wp, cv, off, f8;
	logic [4:0] wi, ci;
	logic [7:0] cd;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	assign f8 = cv && (ci == 5'h8);
	// write address phase; its data lands at the next accepted edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wp <= 1'b0;
			wi <= 5'h0;
		end else if (hready) begin
			wp <= hsel && htrans[1] && hwrite;
			wi <= haddr[6:2];
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cv <= 1'b0;
			ci <= 5'h0;
			cd <= 8'h00;
			off <= 1'b0;
		end else begin
			cv <= wp && hready;
			if (wp && hready) begin
				ci <= wi;
				cd <= hwdata[7:0];
			end
			if (wp && hready && wi == 5'h9) begin
				off <= hwdata[0];
			end
		end
	end
	AST_BW_SEL: assert property (f8 && !cd[4] |-> ##[0:1] filter_bw_code == {1'b0, cd[6:5]})
		else $error("bandwidth code");
	AST_WIDEST: assert property (f8 && cd[4] |-> ##[0:1] filter_bw_code == 3'h4)
		else $error("widest not forced");
	AST_CALIB: assert property (f8 && !cd[4] && cd[3:2] == 2'h3 |-> ##[0:1] filter_calib)
		else $error("no calibration pulse");
	AST_INIT: assert property (f8 && cd[1:0] == 2'h3 |-> ##[0:1] filter_init)
		else $error("no init pulse");
	AST_MODE: assert property (cv && ci == 5'ha |-> ##[0:1] mode_linear == cd[5])
		else $error("mode copy");
	AST_DET_CAUSE: assert property (pattern_detect |-> $past(rx_bit_valid))
		else $error("detect without bit");
	AST_FILL: assert property (fifo_fill_start == (pattern_detect && !$past(fill_select)))
		else $error("fill start");
	AST_APPLY_OFF: assert property (off |=> $stable(lo_correction))
		else $error("correction applied");
endmodule // rxcpm_top_chk
bind rxcpm_top rxcpm_top_chk i_chk (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .rx_bit_valid, .fill_select, .filter_bw_code, .filter_calib,
	.filter_init, .mode_linear, .lo_correction, .pattern_detect, .fifo_fill_start);

// [verilog/rxcpm_defs.svh]
/*
 rxcpm_defs.svh: register indices, field positions, reset values and counts
 for the receiver configuration and pattern matcher block.
 assumes: included by bare name by the top module.
*/
`ifndef RXCPM_DEFS_SVH
`define RXCPM_DEFS_SVH
`define RXCPM_IDX_FILTER 5'h8
`define RXCPM_IDX_CORR 5'h9
`define RXCPM_IDX_MODE 5'ha
`define RXCPM_IDX_FEI_HI 5'hb
`define RXCPM_IDX_FEI_LO 5'hc
`define RXCPM_IDX_PAT0 5'hd
`define RXCPM_IDX_PAT1 5'he
`define RXCPM_IDX_PAT2 5'hf
`define RXCPM_IDX_PAT3 5'h10
`define RXCPM_BIT_RUN 2
`define RXCPM_BIT_OVF 7
`define RXCPM_RST_FILTER 8'h00
`define RXCPM_RST_CORR 8'h00
`define RXCPM_RST_MODE 8'h00
`define RXCPM_RST_PAT 32'h0000_0000
`define RXCPM_WIDEST_CODE 3'h4
`define RXCPM_AFC_CYCLES 16'h0040
`define RXCPM_INTEG_LIMIT 20'h0_8000
`define RXCPM_AFC_ERR_LIMIT 16'h0100
`endif

// [verilog/rxcpm_pkg.sv]
/*
 rxcpm_pkg: types shared by the receiver configuration block.
 assumes: nothing beyond the defs header.
*/
package rxcpm_pkg;
	typedef struct packed {
		logic bitsync_off;
		logic [1:0] bw_sel;
		logic widest;
		logic [1:0] calib;
		logic [1:0] init;
	} rxcpm_filt_type;
	typedef struct packed {
		logic iq_amp_on;
		logic mode_linear;
		logic pat_en;
		logic [1:0] pat_size;
		logic [1:0] pat_tol;
	} rxcpm_mode_type;
	typedef enum logic {rxcpm_idle, rxcpm_run} rxcpm_afc_type;
endpackage

// [verilog/rxcpm_top.sv]
/*
 rxcpm_top: receiver settings register bank on AHB-Lite, frequency
 correction sequencer and reference pattern matcher.
 assumes: single AHB-Lite master, word accesses only, inputs synchronous
 to mclk, demodulated bits arrive as one-cycle strobes.
*/
// Notes on behaviour
// - two bit field picks 10/20/40/200 kHz
// - widest bit forces widest filter, no calibration
// - calibration policy: startup, never, change, write
// - filter init: startup, reserved, change, forced
// - strength band read from three thresholds
// - bit 3 enables frequency error indicator
// - writing 0 starts correction, self clears
// - bit 1 reports correction failure
// - disable bit stops applying correction
// - overflow flag set; writing 1 resets integrator
// - mode bit picks sensitivity or linearity
// - bit 4 enables pattern recognition
// - size field picks 8 to 32 bits
// - tolerance field allows zero to three errors
// - signed error result, high then low byte
// - pattern bytes 13 to 16, MSB first
// - earliest bit meets pattern MSB
// - detection starts fifo fill when fill_select is low
`timescale 1ns/1ps
`include "rxcpm_defs.svh"
module rxcpm_top import rxcpm_pkg::*; #(
	parameter logic [7:0] strength_threshold_1 = 8'h40,
	parameter logic [7:0] strength_threshold_2 = 8'h80,
	parameter logic [7:0] strength_threshold_3 = 8'hc0,
	parameter logic [15:0] afc_cycles = `RXCPM_AFC_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [7:0] power_level,
	input wire logic [15:0] freq_err_meas,
	input wire logic freq_err_meas_valid,
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	input wire logic fill_select,
	output logic [2:0] filter_bw_code,
	output logic filter_calib,
	output logic filter_init,
	output logic bitsync_off,
	output logic rssi_on,
	output logic rssi_high_range,
	output logic iq_amp_on,
	output logic mode_linear,
	output logic [15:0] lo_correction,
	output logic pattern_detect,
	output logic fifo_fill_start
);
	logic accept;
	logic map_hit;
	logic wr_pend;
	logic rd_pend;
	logic [4:0] wr_idx;
	logic [4:0] rd_idx;
	logic [7:0] wbyte;
	logic wr_filter;
	logic wr_corr;
	logic wr_mode;
	rxcpm_filt_type filt;
	rxcpm_mode_type mode;
	logic rssi_en;
	logic rssi_rng;
	logic fei_en;
	logic apply_off;
	logic corr_fail;
	logic corr_ovf;
	logic [1:0] signal_strength_band;
	logic [15:0] freq_error_value;
	logic signed [19:0] integ;
	logic [19:0] integ_mag;
	logic [15:0] err_mag;
	logic [15:0] afc_cnt;
	rxcpm_afc_type afc_state;
	logic freq_corr_run;
	logic afc_end;
	logic ovf_set;
	logic [31:0] pattern;
	logic [31:0] hist;
	logic [5:0] hist_cnt;
	logic [5:0] pat_len;
	logic [31:0] pat_mask;
	logic [31:0] ref_bits;
	logic [31:0] cand;
	logic [5:0] mism;
	logic [2:0] eff_bw;
	logic [2:0] prev_bw;
	logic started;
	logic [7:0] rd_mux;

	// bus decode: word aligned, indices 8..16 only
	assign accept = hsel & htrans[1] & hready;
	assign map_hit = (haddr[31:7] == 25'h000_0000) & (haddr[1:0] == 2'h0) &
		(haddr[6:2] >= `RXCPM_IDX_FILTER) & (haddr[6:2] <= `RXCPM_IDX_PAT3);
	assign wbyte = hwdata[7:0];
	assign wr_filter = wr_pend & (wr_idx == `RXCPM_IDX_FILTER);
	assign wr_corr = wr_pend & (wr_idx == `RXCPM_IDX_CORR);
	assign wr_mode = wr_pend & (wr_idx == `RXCPM_IDX_MODE);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			wr_idx <= 5'h00;
			rd_idx <= 5'h00;
		end else begin
			wr_pend <= accept & hwrite & map_hit;
			rd_pend <= accept & ~hwrite;
			wr_idx <= haddr[6:2];
			rd_idx <= map_hit ? haddr[6:2] : 5'h00;
		end
	end

	// reads take one wait state so hrdata can come from a flop
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			hreadyout <= ~(accept & ~hwrite);
			hresp <= 1'b0;
			if (rd_pend) begin
				hrdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	always_comb begin
		case (rd_idx)
			`RXCPM_IDX_FILTER: rd_mux = filt;
			`RXCPM_IDX_CORR: rd_mux = {rssi_en, rssi_rng, signal_strength_band, fei_en,
				afc_state == rxcpm_run, corr_fail, apply_off};
			`RXCPM_IDX_MODE: rd_mux = {corr_ovf, mode};
			`RXCPM_IDX_FEI_HI: rd_mux = freq_error_value[15:8];
			`RXCPM_IDX_FEI_LO: rd_mux = freq_error_value[7:0];
			`RXCPM_IDX_PAT0: rd_mux = pattern[31:24];
			`RXCPM_IDX_PAT1: rd_mux = pattern[23:16];
			`RXCPM_IDX_PAT2: rd_mux = pattern[15:8];
			`RXCPM_IDX_PAT3: rd_mux = pattern[7:0];
			default: rd_mux = 8'h00;
		endcase
	end

	// settings registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			filt <= `RXCPM_RST_FILTER;
		end else if (wr_filter) begin
			filt <= wbyte;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rssi_en <= 1'b0;
			rssi_rng <= 1'b0;
			fei_en <= 1'b0;
			apply_off <= 1'b0;
		end else if (wr_corr) begin
			rssi_en <= wbyte[7];
			rssi_rng <= wbyte[6];
			fei_en <= wbyte[3];
			apply_off <= wbyte[0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode <= 7'h00;
		end else if (wr_mode) begin
			mode <= wbyte[6:0];
		end
	end

	// byte 13 holds the pattern MSB
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pattern <= `RXCPM_RST_PAT;
		end else if (wr_pend) begin
			case (wr_idx)
				`RXCPM_IDX_PAT0: pattern[31:24] <= wbyte;
				`RXCPM_IDX_PAT1: pattern[23:16] <= wbyte;
				`RXCPM_IDX_PAT2: pattern[15:8] <= wbyte;
				`RXCPM_IDX_PAT3: pattern[7:0] <= wbyte;
				default: pattern <= pattern;
			endcase
		end
	end

	// filter bandwidth, calibration and initialisation
	// software must keep bw at or above deviation plus half the rate
	assign eff_bw = filt.widest ? `RXCPM_WIDEST_CODE : {1'b0, filt.bw_sel};

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			filter_bw_code <= 3'h0;
			prev_bw <= 3'h0;
			started <= 1'b0;
		end else begin
			filter_bw_code <= eff_bw;
			prev_bw <= eff_bw;
			started <= 1'b1;
		end
	end

	// widest setting never calibrates, whatever the policy
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			filter_calib <= 1'b0;
		end else if (wr_filter ? wbyte[4] : filt.widest) begin
			filter_calib <= 1'b0;
		end else begin
			// a write is judged on the policy it brings, else a first write of 11 is lost
			case (wr_filter ? wbyte[3:2] : filt.calib)
				2'h0: filter_calib <= ~started;
				2'h2: filter_calib <= started & (eff_bw != prev_bw);
				2'h3: filter_calib <= wr_filter & (wbyte[3:2] == 2'h3);
				default: filter_calib <= 1'b0;
			endcase
		end
	end

	// reserved init code 01 does nothing
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			filter_init <= 1'b0;
		end else begin
			case (wr_filter ? wbyte[1:0] : filt.init)
				2'h0: filter_init <= ~started;
				2'h2: filter_init <= started & (eff_bw != prev_bw);
				2'h3: filter_init <= wr_filter & (wbyte[1:0] == 2'h3);
				default: filter_init <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bitsync_off <= 1'b0;
			rssi_on <= 1'b0;
			rssi_high_range <= 1'b0;
			iq_amp_on <= 1'b0;
			mode_linear <= 1'b0;
		end else begin
			bitsync_off <= filt.bitsync_off;
			rssi_on <= rssi_en;
			rssi_high_range <= rssi_rng;
			iq_amp_on <= mode.iq_amp_on;
			mode_linear <= mode.mode_linear;
		end
	end

	// signal strength band
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			signal_strength_band <= 2'h0;
		end else if (power_level >= strength_threshold_3) begin
			signal_strength_band <= 2'h3;
		end else if (power_level > strength_threshold_2) begin
			signal_strength_band <= 2'h2;
		end else if (power_level > strength_threshold_1) begin
			signal_strength_band <= 2'h1;
		end else begin
			signal_strength_band <= 2'h0;
		end
	end

	// frequency error indicator and correction
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			freq_error_value <= 16'h0000;
		end else if (fei_en & freq_err_meas_valid) begin
			freq_error_value <= freq_err_meas;
		end
	end

	assign freq_corr_run = wr_corr & ~wbyte[`RXCPM_BIT_RUN] & (afc_state == rxcpm_idle);
	assign afc_end = (afc_state == rxcpm_run) & (afc_cnt == afc_cycles - 16'h0001);
	assign err_mag = freq_error_value[15] ? 16'(-freq_error_value) : freq_error_value;
	assign integ_mag = integ[19] ? 20'(-integ) : 20'(integ);
	assign ovf_set = integ_mag >= `RXCPM_INTEG_LIMIT;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			afc_state <= rxcpm_idle;
			afc_cnt <= 16'h0000;
		end else begin
			case (afc_state)
				rxcpm_idle: begin
					afc_cnt <= 16'h0000;
					if (freq_corr_run) begin
						afc_state <= rxcpm_run;
					end
				end
				rxcpm_run: begin
					afc_cnt <= afc_cnt + 16'h0001;
					if (afc_end) begin
						afc_state <= rxcpm_idle;
					end
				end
				default: afc_state <= rxcpm_idle;
			endcase
		end
	end

	// failure if the integrator overflowed or the residual error is large
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			corr_fail <= 1'b0;
			lo_correction <= 16'h0000;
		end else if (afc_end) begin
			corr_fail <= corr_ovf | ovf_set | (err_mag > `RXCPM_AFC_ERR_LIMIT);
			if (!apply_off) begin
				lo_correction <= integ[15:0];
			end
		end
	end

	// integrator only runs during a correction; writing 1 resets it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			integ <= 20'sh0_0000;
		end else if (wr_mode & wbyte[`RXCPM_BIT_OVF]) begin
			integ <= 20'sh0_0000;
		end else if ((afc_state == rxcpm_run) & fei_en & freq_err_meas_valid & ~ovf_set) begin
			integ <= integ + 20'(signed'(freq_err_meas));
		end
	end

	// a new overflow wins over the software clear; a standing one must not block it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			corr_ovf <= 1'b0;
		end else if (ovf_set & ~corr_ovf) begin
			corr_ovf <= 1'b1;
		end else if (wr_mode & wbyte[`RXCPM_BIT_OVF]) begin
			corr_ovf <= 1'b0;
		end
	end

	// pattern matcher: newest bit in hist[0]
	assign pat_len = {2'h0, mode.pat_size, 2'h0} + {2'h0, mode.pat_size, 2'h0} + 6'h08;
	assign pat_mask = 32'hffff_ffff >> (6'h20 - pat_len);
	assign ref_bits = pattern >> (6'h20 - pat_len);
	assign cand = (hist ^ ref_bits) & pat_mask;

	always_comb begin
		mism = 6'h00;
		for (int i = 0; i < 32; i++) begin
			mism = mism + {5'h00, cand[i]};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hist <= 32'h0000_0000;
			hist_cnt <= 6'h00;
		end else if (!mode.pat_en) begin
			hist_cnt <= 6'h00;
		end else if (rx_bit_valid) begin
			hist <= {hist[30:0], rx_bit};
			hist_cnt <= (hist_cnt == 6'h20) ? hist_cnt : hist_cnt + 6'h01;
		end
	end

	// compared once per new bit, after enough bits have arrived
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pattern_detect <= 1'b0;
			fifo_fill_start <= 1'b0;
		end else begin
			pattern_detect <= mode.pat_en & rx_bit_valid & (hist_cnt >= pat_len) &
				(mism <= {4'h0, mode.pat_tol});
			fifo_fill_start <= mode.pat_en & rx_bit_valid & (hist_cnt >= pat_len) &
				(mism <= {4'h0, mode.pat_tol}) & ~fill_select;
		end
	end

	logic unused_ok;
	assign unused_ok = ^{hsize, hwdata[31:8]};
endmodule // rxcpm_top
